// ===== alarm_outputs.v
// limit alarms, system alarm events and the 32 digital alarm outputs
// Function
// - value beyond high or low limit alarms
// - alarm clears only past high limit minus or low limit plus hysteresis
// - system alarm while any channel alarms
// - alarm start source makes alarm a start trigger
// - only scanned channels may raise alarms
// - alarms evaluate only while acquisition armed
// - exactly 32 outputs, expansion channels feed them
// - many channels may OR onto one output
// - assignment names one channel or range
// - host forces 8-bit banks to given levels
// - forced value overrides alarm-derived value
// - output line state readable by host
// - fast variant updates at every conversion
// - scan variant updates only on buffered scans
// - codes 9 and 10: alarm enter, leave
`timescale 1ns/1ps
`include "alarm_map.vh"
module alarm_outputs (
    input  wire                 clock_i,        // 125 MHz clock
    input  wire                 nrst_i,         // async reset, active low
    input  wire                 arm_i,          // acquisition armed, level
    input  wire                 scan_rate_i,    // 1: scan-rate variant
    input  wire                 conv_valid_i,   // one converted value
    input  wire                 conv_in_scan_i, // value goes to buffer
    input  wire [`CHAN_W-1:0]   conv_chan_i,    // its channel number
    input  wire [`VAL_W-1:0]    conv_value_i,   // its value, signed
    input  wire                 cfg_we_i,       // channel config write
    input  wire [`CHAN_W-1:0]   cfg_first_i,    // first channel of range
    input  wire [`CHAN_W-1:0]   cfg_last_i,     // last channel of range
    input  wire [1:0]           cfg_sel_i,      // which item to write
    input  wire [`VAL_W-1:0]    cfg_data_i,     // item value
    input  wire                 map_we_i,       // output assignment write
    input  wire [`CHAN_W-1:0]   map_first_i,    // first channel of range
    input  wire [`CHAN_W-1:0]   map_last_i,     // last channel of range
    input  wire [`OUT_W-1:0]    map_out_i,      // target output line
    input  wire                 map_clr_i,      // drop all assignments
    input  wire                 force_we_i,     // force one bank
    input  wire [1:0]           force_bank_i,   // bank number
    input  wire [`BANK_W-1:0]   force_data_i,   // levels, 1 high
    input  wire                 force_rel_i,    // give lines back to alarms
    input  wire [3:0]           start_src_i,    // start event source code
    input  wire [3:0]           stop_src_i,     // stop event source code
    output reg  [`NUM_OUT-1:0]  dout_o,         // digital output lines
    output reg  [`NUM_OUT-1:0]  dout_rb_o,      // readback of the lines
    output reg                  sys_alarm_o,    // any channel in alarm
    output reg                  alarm_on_o,     // a channel entered alarm
    output reg                  alarm_off_o,    // a channel left alarm
    output reg                  start_trig_o,   // start trigger pulse
    output reg                  stop_trig_o     // stop trigger pulse
);
    // per channel setpoints; all inputs come from logic on this clock
    reg [`VAL_W-1:0]    high_mem [0:`NUM_CHAN-1];  // high setpoints
    reg [`VAL_W-1:0]    low_mem  [0:`NUM_CHAN-1];  // low setpoints
    reg [`VAL_W-1:0]    hyst_mem [0:`NUM_CHAN-1];  // hysteresis values
    reg [`OUT_W-1:0]    map_out  [0:`NUM_CHAN-1];  // assigned output
    reg [`NUM_CHAN-1:0] map_on;                    // channel assigned
    reg [`NUM_CHAN-1:0] in_scan;                   // channel in scan list
    reg [`NUM_CHAN-1:0] al_hi;                     // high alarm state
    reg [`NUM_CHAN-1:0] al_lo;                     // low alarm state
    reg [`NUM_OUT-1:0]  force_en;                  // line is forced
    reg [`NUM_OUT-1:0]  force_val;                 // forced level
    wire                next_hi;                   // evaluated high
    wire                next_lo;                   // evaluated low
    wire [`NUM_CHAN-1:0] alarm = al_hi | al_lo;    // channel in alarm
    wire                cur_al;                    // addressed channel
    wire                next_al = next_hi | next_lo;
    reg                 eval;                      // evaluate this value
    wire [`NUM_OUT-1:0] alarm_lines;               // alarm-derived lines
    reg [`NUM_OUT-1:0]  next_dout;                 // lines after force
    // one loop index per process, so no variable has two drivers
    integer             i;                         // setpoint loop index
    integer             j;                         // channel state index
    integer             k;                         // force bank index

    // range membership, used by config and assignment writes
    function in_range;
        input [`CHAN_W-1:0] ch;
        input [`CHAN_W-1:0] first;
        input [`CHAN_W-1:0] last;
        begin
            in_range = (ch >= first) && (ch <= last);
        end
    endfunction

    assign cur_al = alarm[conv_chan_i];

    // fast variant takes every conversion, the scan variant only the
    // buffered ones, so every alarm it reports is in the buffered data
    always @* begin
        eval = conv_valid_i && arm_i && in_scan[conv_chan_i] &&
               (!scan_rate_i || conv_in_scan_i);
    end

    alarm_eval u_eval (
        .value_i   (conv_value_i),
        .high_i    (high_mem[conv_chan_i]),
        .low_i     (low_mem[conv_chan_i]),
        .hyst_i    (hyst_mem[conv_chan_i]),
        .hi_i      (al_hi[conv_chan_i]),
        .lo_i      (al_lo[conv_chan_i]),
        .next_hi_o (next_hi),
        .next_lo_o (next_lo)
    );

    // setpoint memory; no reset, host loads it before arming
    always @(posedge clock_i) begin
        for (i = 0; i < `NUM_CHAN; i = i + 1) begin
            if (cfg_we_i && in_range(i[`CHAN_W-1:0], cfg_first_i,
                                     cfg_last_i)) begin
                if (cfg_sel_i == `CFG_SEL_HIGH)
                    high_mem[i] <= cfg_data_i;
                else if (cfg_sel_i == `CFG_SEL_LOW)
                    low_mem[i] <= cfg_data_i;
                else if (cfg_sel_i == `CFG_SEL_HYST)
                    hyst_mem[i] <= cfg_data_i;
            end
            if (map_we_i && in_range(i[`CHAN_W-1:0], map_first_i,
                                     map_last_i))
                map_out[i] <= map_out_i;
        end
    end

    // scan list, assignment flags and alarm states
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            in_scan <= {`NUM_CHAN{1'b0}};
            map_on  <= {`NUM_CHAN{1'b0}};
            al_hi   <= {`NUM_CHAN{1'b0}};
            al_lo   <= {`NUM_CHAN{1'b0}};
        end else begin
            for (j = 0; j < `NUM_CHAN; j = j + 1) begin
                // scan list write, lowest data bit is membership
                if (cfg_we_i && cfg_sel_i == `CFG_SEL_SCAN &&
                    in_range(j[`CHAN_W-1:0], cfg_first_i, cfg_last_i))
                    in_scan[j] <= cfg_data_i[0];
                // assignment: clear wins only over channels not rewritten
                if (map_we_i && in_range(j[`CHAN_W-1:0], map_first_i,
                                         map_last_i))
                    map_on[j] <= 1'b1;
                else if (map_clr_i)
                    map_on[j] <= 1'b0;
                // disarmed or unscanned channels hold no alarm
                if (!arm_i || !in_scan[j]) begin
                    al_hi[j] <= 1'b0;
                    al_lo[j] <= 1'b0;
                end else if (eval && conv_chan_i == j[`CHAN_W-1:0]) begin
                    al_hi[j] <= next_hi;
                    al_lo[j] <= next_lo;
                end
            end
        end
    end

    // force registers; a bank write holds until released
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            force_en  <= {`NUM_OUT{1'b0}};
            force_val <= {`NUM_OUT{1'b0}};
        end else begin
            if (force_rel_i)
                force_en <= {`NUM_OUT{1'b0}};
            for (k = 0; k < `NUM_BANK; k = k + 1) begin
                if (force_we_i && force_bank_i == k[1:0]) begin
                    force_en[k*`BANK_W +: `BANK_W]  <= {`BANK_W{1'b1}};
                    force_val[k*`BANK_W +: `BANK_W] <= force_data_i;
                end
            end
        end
    end

    // OR of every assigned channel onto its output line
    genvar g;
    generate
        for (g = 0; g < `NUM_OUT; g = g + 1) begin : g_line
            // line number at the width of an assignment entry
            localparam [`OUT_W-1:0] LINE = g;
            integer c;                             // channel index
            reg     hit;                           // some channel drives it
            always @* begin
                hit = 1'b0;
                for (c = 0; c < `NUM_CHAN; c = c + 1) begin
                    if (alarm[c] && map_on[c] &&
                        map_out[c] == LINE)
                        hit = 1'b1;
                end
            end
            assign alarm_lines[g] = hit;
        end
    endgenerate

    // forced bits win over whatever the alarms say
    always @* begin
        next_dout = (force_en & force_val) |
                    (~force_en & alarm_lines);
    end

    // registered outputs and event pulses
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dout_o       <= {`NUM_OUT{1'b0}};
            dout_rb_o    <= {`NUM_OUT{1'b0}};
            sys_alarm_o  <= 1'b0;
            alarm_on_o   <= 1'b0;
            alarm_off_o  <= 1'b0;
            start_trig_o <= 1'b0;
            stop_trig_o  <= 1'b0;
        end else begin
            dout_o      <= next_dout;
            dout_rb_o   <= next_dout;
            sys_alarm_o <= |alarm;
            // a disarm clearing alarms is not reported as leaving
            alarm_on_o  <= eval && !cur_al && next_al;
            alarm_off_o <= eval && cur_al && !next_al;
            start_trig_o <= eval &&
                ((start_src_i == `SRC_ALARM_ON && !cur_al && next_al) ||
                 (start_src_i == `SRC_ALARM_OFF && cur_al && !next_al));
            stop_trig_o <= eval &&
                ((stop_src_i == `SRC_ALARM_ON && !cur_al && next_al) ||
                 (stop_src_i == `SRC_ALARM_OFF && cur_al && !next_al));
        end
    end
endmodule // alarm_outputs

// ===== alarm_map.vh
// constants for the channel alarm and digital output block
`ifndef ALARM_MAP_VH
`define ALARM_MAP_VH
`define NUM_CHAN       64
`define CHAN_W         6
`define VAL_W          16
`define NUM_OUT        32
`define OUT_W          5
`define BANK_W         8
`define NUM_BANK       4
`define CFG_SEL_HIGH   2'h0
`define CFG_SEL_LOW    2'h1
`define CFG_SEL_HYST   2'h2
`define CFG_SEL_SCAN   2'h3
`define SRC_ALARM_ON   4'h9
`define SRC_ALARM_OFF  4'hA
`define HIGH_RST       16'h7FFF
`define LOW_RST        16'h8000
`define HYST_RST       16'h0000
`endif

// ===== alarm_eval.v
// one channel limit compare with hysteresis, next state from current
`timescale 1ns/1ps
`include "alarm_map.vh"
module alarm_eval (
    input  wire signed [`VAL_W-1:0] value_i,   // measured value
    input  wire signed [`VAL_W-1:0] high_i,    // high setpoint
    input  wire signed [`VAL_W-1:0] low_i,     // low setpoint
    input  wire        [`VAL_W-1:0] hyst_i,    // hysteresis, unsigned
    input  wire                     hi_i,      // now in high alarm
    input  wire                     lo_i,      // now in low alarm
    output reg                      next_hi_o, // next high alarm
    output reg                      next_lo_o  // next low alarm
);
    // two guard bits: a limit near the rail minus a full-scale unsigned
    // hysteresis needs them, one bit alone would wrap
    wire signed [`VAL_W+1:0] v_x    = {{2{value_i[`VAL_W-1]}}, value_i};
    wire signed [`VAL_W+1:0] hi_x   = {{2{high_i[`VAL_W-1]}}, high_i};
    wire signed [`VAL_W+1:0] lo_x   = {{2{low_i[`VAL_W-1]}}, low_i};
    wire signed [`VAL_W+1:0] hy_x   = {2'b00, hyst_i};
    wire signed [`VAL_W+1:0] hi_rel = hi_x - hy_x; // high release point
    wire signed [`VAL_W+1:0] lo_rel = lo_x + hy_x; // low release point

    // strict compares: equal to a setpoint or release point changes nothing
    always @* begin
        next_hi_o = hi_i;
        next_lo_o = lo_i;
        if (hi_i) begin
            if (v_x < hi_rel)
                next_hi_o = 1'b0;
        end else if (v_x > hi_x) begin
            next_hi_o = 1'b1;
        end
        if (lo_i) begin
            if (v_x > lo_rel)
                next_lo_o = 1'b0;
        end else if (v_x < lo_x) begin
            next_lo_o = 1'b1;
        end
    end
endmodule // alarm_eval

// ===== ttl_load.sv
// receiver model for the external ttl loads on the output lines
`timescale 1ns/1ps
module ttl_load (
    input  wire logic        clock_i, // instrument clock
    input  wire logic [31:0] lines_i, // the 32 driven lines
    output logic      [31:0] seen_o   // level latched by the load
);
    // the loads latch one clock late, so stale lines show up here
    always @(posedge clock_i) seen_o <= lines_i;
endmodule // ttl_load

// ===== alarm_outputs_checker.sv
// port assertions for the channel alarm output block
`timescale 1ns/1ps
`include "alarm_map.vh"
module alarm_outputs_checker (
    input wire logic        clock_i,
    input wire logic        nrst_i,
    input wire logic        arm_i,
    input wire logic        force_we_i,
    input wire logic [1:0]  force_bank_i,
    input wire logic [7:0]  force_data_i,
    input wire logic [3:0]  start_src_i,
    input wire logic [3:0]  stop_src_i,
    input wire logic [31:0] dout_o,
    input wire logic [31:0] dout_rb_o,
    input wire logic        sys_alarm_o,
    input wire logic        alarm_on_o,
    input wire logic        alarm_off_o,
    input wire logic        start_trig_o,
    input wire logic        stop_trig_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // three sampled edges disarmed: states clear at the first, the
    // registered system level follows one edge after that
    sequence disarmed;
        !arm_i [*3];
    endsequence
    // entry pulse while the start source stays on the entry code
    sequence entry_start;
        alarm_on_o && start_src_i == `SRC_ALARM_ON && $stable(start_src_i);
    endsequence
    // leave pulse while the stop source stays on the leave code
    sequence leave_stop;
        alarm_off_o && stop_src_i == `SRC_ALARM_OFF && $stable(stop_src_i);
    endsequence
    // either channel event pulse
    sequence any_evt;
        alarm_on_o || alarm_off_o;
    endsequence
    AST_RB: assert property (dout_rb_o == dout_o)
        else $error("readback differs from lines");
    // the system level is registered from the states, one edge behind
    AST_ON_SYS: assert property (alarm_on_o |=> sys_alarm_o)
        else $error("entry without system alarm");
    AST_ONE_EVT: assert property (!(alarm_on_o && alarm_off_o))
        else $error("entry and leave together");
    AST_START: assert property (entry_start |-> start_trig_o)
        else $error("alarm entry gave no start trigger");
    AST_STOP: assert property (leave_stop |-> stop_trig_o)
        else $error("alarm leave gave no stop trigger");
    AST_TRIG_CAUSE: assert property (start_trig_o |-> any_evt)
        else $error("start trigger without alarm event");
    AST_DISARM: assert property (
        disarmed |-> !sys_alarm_o && !alarm_on_o)
        else $error("alarm while disarmed");
    AST_FORCE: assert property (
        force_we_i |-> ##2 ((dout_o >> {$past(force_bank_i, 2), 3'h0}) &
        32'hFF) == $past(force_data_i, 2))
        else $error("forced bank not on lines");
endmodule // alarm_outputs_checker

// ===== alarm_outputs_tb.sv
// self-checking bench for the channel alarm output block
`timescale 1ns/1ps
`include "alarm_map.vh"
module alarm_outputs_tb;
    logic        clock_i, nrst_i, arm_i, scan_rate_i, conv_valid_i;
    logic        conv_in_scan_i, cfg_we_i, map_we_i, map_clr_i;
    logic        force_we_i, force_rel_i;
    logic [5:0]  conv_chan_i, cfg_first_i, cfg_last_i;
    logic [5:0]  map_first_i, map_last_i;
    logic [15:0] conv_value_i, cfg_data_i;
    logic [4:0]  map_out_i;
    logic [1:0]  cfg_sel_i, force_bank_i;
    logic [7:0]  force_data_i;
    logic [3:0]  start_src_i, stop_src_i;
    wire  [31:0] dout_o, dout_rb_o, seen;
    wire         sys_alarm_o, alarm_on_o, alarm_off_o;
    wire         start_trig_o, stop_trig_o;
    int          n_errors, num_checks, cyc, frc, mclr;
    bit          ah[4], al[4];  // model high and low alarm sides
    logic [31:0] fv;            // forced levels
    logic [15:0] cv[4] = '{16'h0064, 16'hFF9C, 16'h000A, 16'h0001};
    int dc[11] = '{0, 0, 0, 0, 0, 1, 2, 1, 1, 3, 2};
    int dv[11] = '{100, 101, 91, 90, 89, -101, -150, -90, -89, 200, -89};
    alarm_outputs alarm_outputs_i (.clock_i, .nrst_i, .arm_i, .scan_rate_i,
        .conv_valid_i, .conv_in_scan_i, .conv_chan_i, .conv_value_i,
        .cfg_we_i, .cfg_first_i, .cfg_last_i, .cfg_sel_i, .cfg_data_i,
        .map_we_i, .map_first_i, .map_last_i, .map_out_i, .map_clr_i,
        .force_we_i, .force_bank_i, .force_data_i, .force_rel_i,
        .start_src_i, .stop_src_i, .dout_o, .dout_rb_o, .sys_alarm_o,
        .alarm_on_o, .alarm_off_o, .start_trig_o, .stop_trig_o);
    ttl_load ttl_load_i (.clock_i, .lines_i(dout_o), .seen_o(seen));
    // 125 MHz clock
    initial begin
        clock_i = 0;
        forever #4 clock_i = ~clock_i;
    end
    task tick;
        @(posedge clock_i);
        #1;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
            n_errors++;
        end
    endtask
    // expected lines: ch0 on line 1, ch1 or ch2 on line 2
    function logic [31:0] amap;
        amap = {29'h0, ah[1] | al[1] | ah[2] | al[2], ah[0] | al[0], 1'b0};
        if (mclr) amap = 0;
        if (frc) amap = fv;
    endfunction
    // one conversion, then compare pulses, system alarm and lines with the model
    task conv(input int c, input int v, input bit ins);
        bit p, h, l, ev;
        ev = arm_i && c < 3 &&
             (!scan_rate_i || ins);
        p = ah[c] | al[c];
        h = ah[c] ? !(v < 90) : v > 100;
        l = al[c] ? !(v > -90) : v < -100;
        conv_chan_i = c[5:0];
        conv_value_i = v[15:0];
        conv_in_scan_i = ins;
        conv_valid_i = 1;
        tick;
        conv_valid_i = 0;
        if (ev) begin
            ah[c] = h;
            al[c] = l;
        end
        // pulses stand for the cycle after the evaluating edge
        chk(alarm_on_o, ev && !p && (h | l));
        chk(alarm_off_o, ev && p && !(h | l));
        chk(start_trig_o, ev && !p && (h | l));
        chk(stop_trig_o, ev && p && !(h | l));
        // levels are registered from the new states one edge later
        tick;
        chk(sys_alarm_o, ah[0] | al[0] | ah[1] |
            al[1] | ah[2] | al[2]);
        chk(dout_o, amap());
    endtask
    task finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, the run needs under two hundred cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            finish_test;
        end
    end
    initial begin
        {arm_i, scan_rate_i, conv_valid_i, conv_in_scan_i, cfg_we_i} = 0;
        {map_we_i, map_clr_i, force_we_i, force_rel_i, force_data_i} = 0;
        {conv_chan_i, cfg_first_i, cfg_last_i, map_first_i} = 0;
        {map_last_i, conv_value_i, cfg_data_i, map_out_i, cfg_sel_i} = 0;
        {force_bank_i, start_src_i, stop_src_i, nrst_i} = 0;
        void'($urandom(32'hf016));
        repeat (4) @(posedge clock_i);
        #1 nrst_i = 1;
        tick;
        chk(dout_o, 0);
        $display("reset test done");
        start_src_i = `SRC_ALARM_ON;
        stop_src_i = `SRC_ALARM_OFF;
        cfg_last_i = 3;
        cfg_we_i = 1;
        for (int s = 0; s < 4; s++) begin
            cfg_sel_i = s[1:0];
            cfg_data_i = cv[s];
            if (s == 3) cfg_last_i = 2; // channel 3 left out of the scan
            tick;
        end
        cfg_we_i = 0;
        map_we_i = 1;
        for (int m = 0; m < 3; m++) begin
            map_first_i = m == 2 ? 6'h03 : m[5:0];
            map_last_i = m == 2 ? 6'h00 : {m[4:0], 1'b0}; // empty range
            map_out_i = m == 2 ? 5'h05 : m[4:0] + 5'h01;
            tick;
        end
        map_we_i = 0;
        arm_i = 1;
        tick;
        for (int i = 0; i < 11; i++) conv(dc[i], dv[i], 1);
        for (int i = 0; i < 60; i++) begin
            scan_rate_i = 1'($urandom);
            conv($urandom_range(3), int'($urandom_range(400)) - 200,
                1'($urandom));
        end
        $display("alarm test done");
        force_we_i = 1;
        for (int b = 0; b < 4; b++) begin
            force_bank_i = b[1:0];
            force_data_i = 8'($urandom);
            fv[b*8 +: 8] = force_data_i;
            tick;
        end
        force_we_i = 0;
        frc = 1;
        conv(0, 150, 1);
        conv(1, -150, 1);
        chk(seen, fv);
        force_rel_i = 1;
        tick;
        force_rel_i = 0;
        frc = 0;
        tick;
        chk(dout_rb_o, amap());
        map_clr_i = 1;
        tick;
        map_clr_i = 0;
        mclr = 1;
        tick;
        chk(dout_o, 0);
        $display("force test done");
        arm_i = 0;
        tick;
        tick;
        chk(sys_alarm_o, 0);
        foreach (ah[k]) {ah[k], al[k]} = 0;
        conv(0, 150, 1);
        $display("disarm test done");
        finish_test;
    end
endmodule // alarm_outputs_tb
bind alarm_outputs alarm_outputs_checker alarm_outputs_checker_i (.clock_i,
    .nrst_i, .arm_i, .force_we_i, .force_bank_i, .force_data_i,
    .start_src_i, .stop_src_i, .dout_o, .dout_rb_o, .sys_alarm_o,
    .alarm_on_o, .alarm_off_o, .start_trig_o, .stop_trig_o);
